//--- sssp_master.sv
`timescale 1ns/10ps
// behavioural serial master; the clock only runs inside words
module sssp_master #(
	parameter int HALF_NS = 24
) (
	output logic      sclk,
	output logic      chip_select_n,
	output logic      m_data,
	output logic      m_oe,
	input  wire logic data_line,
	input  wire logic dev_oe
);
	initial begin
		sclk = 1'b0;
		chip_select_n = 1'b1;
		m_data = 1'b0;
		m_oe = 1'b0;
	end

	task automatic select();
		chip_select_n = 1'b0;
		#300;
	endtask

	task automatic release_sel();
		#100;
		chip_select_n = 1'b1;
		m_oe = 1'b0;
		#700;
	endtask

	// give the device time to fetch the register before reading on
	task automatic turn();
		m_oe = 1'b0;
		#400;
	endtask

	task automatic word(input logic [15:0] tx, input logic drv, input int nbits,
		output logic [15:0] rx, output logic oe_any);
		rx = 16'h0;
		oe_any = 1'b0;
		for (int i = 15; i > 15 - nbits; i--) begin
			sclk = 1'b1;
			if (drv) begin
				m_oe = 1'b1;
				m_data = tx[i];
			end
			#(HALF_NS);
			sclk = 1'b0;
			rx[i] = data_line;
			oe_any = oe_any | dev_oe;
			#(HALF_NS);
		end
	endtask
endmodule // sssp_master

//--- sssp_pkg.sv
package sssp_pkg;

	localparam int WORD_W       = 16;
	localparam int ADDR_W       = 6;
	localparam int CNT_W        = 4;
	localparam int NREG         = 64;

	// command word fields
	localparam int CMD_RW_BIT   = 15;
	localparam int CMD_KEY_HI   = 14;
	localparam int CMD_KEY_LO   = 11;
	localparam int CMD_SNAP_BIT = 10;
	localparam int CMD_ADDR_HI  = 9;
	localparam int CMD_ADDR_LO  = 4;
	localparam int CMD_CNT_HI   = 3;
	localparam int CMD_CNT_LO   = 0;

	// safety word fields
	localparam int SAFE_SYS_BIT = 14;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 6'h00;

	localparam logic [7:0] CRC_POLY = 8'h1D;
	localparam logic [7:0] CRC_SEED = 8'hFF;

	// supply spike filter length in digital clocks
	localparam int VR_FILTER_CYC = 256;

	localparam int CLK_PERIOD_NS = 8;
	localparam int WR_DELAY_NS   = 130;
	localparam int WR_DELAY_CYC  = (WR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [3:0] {
		SSSP_CMD  = 4'b0001,
		SSSP_DATA = 4'b0010,
		SSSP_SAFE = 4'b0100,
		SSSP_DONE = 4'b1000
	} sssp_state_t;

	// one crc byte step, msb first
	function automatic logic [7:0] crc8_byte(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c ^ b;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

endpackage

//--- sssp_port.sv
`timescale 1ns/10ps
// Overview of operation
// - words shift msb first both ways
// - drive on rising, sample on falling edge
// - act only on complete 16-bit words
// - safety word follows data when count nonzero
// - select high aborts, resets crc
// - count above one reads consecutive registers
// - address wraps from 3F to 00
// - count zero: one word, no safety
// - clockless select pulse snapshots buffered registers
// - snapshot bit reads buffered copy
// - driver enabled only while sending
// - crc restarts per transfer, covers all bytes
// - crc polynomial x8+x4+x3+x2+1
// - crc seeded with all ones
// - crc remainder inverted in safety word
// - read-only, read-write and buffered bit types
// - supply error needs 256 clocks active
// - supply error clears system error bit
// - command word field layout
// - error bit low until status read
module sssp_port
	import sssp_pkg::*;
#(
	parameter int FILTER_CYC = sssp_pkg::VR_FILTER_CYC
) (
	input  wire logic                        clk,
	input  wire logic                        rst_b,
	input  wire logic                        sclk,
	input  wire logic                        chip_select_n,
	input  wire logic                        data_in,
	output logic                             data_out,
	output logic                             data_oe,
	input  wire logic                        supply_fault,
	input  wire logic [sssp_pkg::ADDR_W-1:0] sens_addr,
	input  wire logic [sssp_pkg::WORD_W-1:0] sens_data,
	input  wire logic                        sens_we,
	output logic                             regulator_voltage_error,
	output logic [sssp_pkg::WORD_W-1:0]      write_word,
	output logic [sssp_pkg::ADDR_W-1:0]      write_addr,
	output logic                             write_strobe
);
	import sssp_pkg::*;

	initial begin
		if (FILTER_CYC < 1 || FILTER_CYC > 65535) $error("FILTER_CYC out of range");
	end

	// ---------------- link domain (serial clock) ----------------
	// reset of link logic is chip select itself, asynchronously
	logic [WORD_W-1:0] sh_q;
	logic [3:0]        bit_q;
	logic              wtog_q;
	logic [WORD_W-1:0] wrd_q;
	logic              tx_q;
	logic [WORD_W-1:0] txsh_q;
	logic [4:0]        txbit_q;
	logic              any_clk_q;

	// sample on falling edge, msb first
	always_ff @(negedge sclk or posedge chip_select_n) begin
		if (chip_select_n) begin
			sh_q   <= '0;
			bit_q  <= '0;
			wtog_q <= 1'b0;
			wrd_q  <= '0;
		end else begin
			sh_q  <= {sh_q[WORD_W-2:0], data_in};
			bit_q <= bit_q + 4'h1;
			if (bit_q == 4'hF) begin
				wrd_q  <= {sh_q[WORD_W-2:0], data_in};
				wtog_q <= ~wtog_q;
			end
		end
	end

	// any clock since select fell, for the snapshot decision
	always_ff @(posedge sclk or posedge chip_select_n) begin
		if (chip_select_n) any_clk_q <= 1'b0;
		else any_clk_q <= 1'b1;
	end

	// transmit: load at word start, change data on rising edge; tx_word_q and
	// ld_tog_q are read without sync: the clk side changes them only mid-word
	// or in the turnaround wait, so they are stable at every loading edge
	logic [WORD_W-1:0] tx_word_q;
	logic              tx_en_q;
	logic              ld_tog_q;
	logic              ld_seen_q;
	always_ff @(posedge sclk or posedge chip_select_n) begin
		if (chip_select_n) begin
			txsh_q    <= '0;
			txbit_q   <= '0;
			tx_q      <= 1'b0;
			ld_seen_q <= 1'b0;
		end else begin
			if (ld_tog_q != ld_seen_q && (txbit_q == 5'h00 || txbit_q == 5'h10)) begin
				ld_seen_q <= ld_tog_q;
				txsh_q    <= {tx_word_q[WORD_W-2:0], 1'b0};
				tx_q      <= tx_word_q[WORD_W-1];
				txbit_q   <= 5'h01;
			end else if (txbit_q == 5'h10) begin
				// last bit stands until the next word begins
				txbit_q <= 5'h00;
			end else if (txbit_q != 5'h00) begin
				txsh_q  <= {txsh_q[WORD_W-2:0], 1'b0};
				tx_q    <= txsh_q[WORD_W-1];
				txbit_q <= txbit_q + 5'h01;
			end
		end
	end
	assign data_out = tx_q;
	assign data_oe  = tx_en_q & ~chip_select_n & (txbit_q != 5'h00);

	// ---------------- system domain ----------------
	logic [2:0] cs_sync_q;
	logic [2:0] wt_sync_q;
	logic [1:0] ac_sync_q;
	logic [2:0] ak_sync_q;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cs_sync_q <= 3'b111;
			wt_sync_q <= '0;
			ac_sync_q <= '0;
			ak_sync_q <= '0;
		end else begin
			cs_sync_q <= {cs_sync_q[1:0], chip_select_n};
			wt_sync_q <= {wt_sync_q[1:0], wtog_q};
			ac_sync_q <= {ac_sync_q[0], any_clk_q};
			ak_sync_q <= {ak_sync_q[1:0], ld_seen_q};
		end
	end
	wire cs_rise  = cs_sync_q[1] & ~cs_sync_q[2];
	wire cs_high  = cs_sync_q[1];
	wire word_evt = (wt_sync_q[1] != wt_sync_q[2]) & ~cs_high;
	// link has taken the offered word: time to prepare the next one
	wire ack_evt  = (ak_sync_q[1] != ak_sync_q[2]) & ~cs_high;

	// the link flag clears together with select, so keep it here until
	// select is seen fully high
	logic clk_seen_q;
	always_ff @(posedge clk) begin
		if (!rst_b || cs_sync_q[2]) clk_seen_q <= 1'b0;
		else if (ac_sync_q[1]) clk_seen_q <= 1'b1;
	end

	sssp_state_t st_q;
	logic [ADDR_W-1:0] addr_q;
	logic [CNT_W-1:0]  left_q;
	logic              snap_sel_q;
	logic              wr_mode_q;
	logic [7:0]        crc_q;
	logic              rd_pend_q;
	logic              status_rd;
	logic [WORD_W-1:0] rd_data;
	logic [WORD_W-1:0] cmd;
	logic [WORD_W-1:0] safe_w;
	assign cmd = wrd_q;
	// reads step when a word is taken, so the next one is ready in time
	logic adv;
	assign adv = wr_mode_q ? word_evt : ack_evt;

	// word received: command, write data or (ignored) pad during reads
	always_ff @(posedge clk) begin
		if (!rst_b || cs_high) begin
			st_q       <= SSSP_CMD;
			addr_q     <= '0;
			left_q     <= '0;
			snap_sel_q <= 1'b0;
			wr_mode_q  <= 1'b0;
			rd_pend_q  <= 1'b0;
		end else begin
			rd_pend_q <= 1'b0;
			case (st_q)
				SSSP_CMD: begin
					if (word_evt) begin
						addr_q     <= cmd[CMD_ADDR_HI:CMD_ADDR_LO];
						snap_sel_q <= cmd[CMD_SNAP_BIT];
						wr_mode_q  <= ~cmd[CMD_RW_BIT];
						left_q     <= cmd[CMD_CNT_HI:CMD_CNT_LO];
						st_q       <= SSSP_DATA;
						rd_pend_q  <= cmd[CMD_RW_BIT];
					end
				end
				SSSP_DATA: begin
					if (adv) begin
						addr_q <= addr_q + 6'h01;
						if (left_q <= 4'h1) begin
							st_q <= (left_q == 4'h0) ? SSSP_DONE : SSSP_SAFE;
						end else begin
							left_q    <= left_q - 4'h1;
							rd_pend_q <= ~wr_mode_q;
						end
					end
				end
				SSSP_SAFE: begin
					if (adv) st_q <= SSSP_DONE;
				end
				default: st_q <= SSSP_DONE;
			endcase
		end
	end

	assign write_strobe = word_evt & (st_q == SSSP_DATA) & wr_mode_q;
	assign write_addr   = addr_q;
	assign write_word   = cmd;
	assign status_rd    = rd_pend_q & (addr_q == STATUS_ADDR);

	sssp_regfile #(.AW(ADDR_W), .DW(WORD_W)) u_regs (
		.clk     (clk),
		.rst_b   (rst_b),
		.wr_addr (sens_addr),
		.wr_data (sens_data),
		.wr_en   (sens_we),
		.snap    (cs_rise & ~clk_seen_q),
		.rd_addr (addr_q),
		.rd_snap (snap_sel_q),
		.rd_data (rd_data)
	);

	// crc over the command, write data and read data words, high byte first
	logic crc_rx;
	logic crc_tx;
	logic [WORD_W-1:0] crc_w;
	assign crc_rx = word_evt & (st_q == SSSP_CMD || (st_q == SSSP_DATA && wr_mode_q));
	always_ff @(posedge clk) begin
		if (!rst_b || cs_high) begin
			crc_q <= CRC_SEED;
		end else if (crc_rx || crc_tx) begin
			crc_q <= crc8_byte(crc8_byte(crc_q, crc_w[15:8]), crc_w[7:0]);
		end
	end

	// supply spike filter and sticky error
	logic [1:0]  sf_sync_q;
	logic [15:0] sf_cnt_q;
	logic        vr_err_q;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sf_sync_q <= '0;
			sf_cnt_q  <= '0;
		end else begin
			sf_sync_q <= {sf_sync_q[0], supply_fault};
			if (!sf_sync_q[1]) sf_cnt_q <= '0;
			else if (sf_cnt_q != 16'(FILTER_CYC)) sf_cnt_q <= sf_cnt_q + 16'h0001;
		end
	end
	wire vr_set = (sf_cnt_q == 16'(FILTER_CYC));
	always_ff @(posedge clk) begin
		if (!rst_b) vr_err_q <= 1'b0;
		else if (vr_set) vr_err_q <= 1'b1;
		else if (status_rd) vr_err_q <= 1'b0;
	end
	assign regulator_voltage_error = vr_err_q;
	assign safe_w = {1'b1, ~vr_err_q, 6'h3F, ~crc_q};

	// hand the next word to the link; one cycle after rd_pend for register read
	logic rd_ld_q;
	logic safe_ld;
	always_ff @(posedge clk) begin
		if (!rst_b || cs_high) rd_ld_q <= 1'b0;
		else rd_ld_q <= rd_pend_q;
	end
	assign safe_ld = ack_evt & (st_q == SSSP_DATA) & (left_q == 4'h1) & ~wr_mode_q;
	logic safe_ld_wr;
	assign safe_ld_wr = word_evt & (st_q == SSSP_DATA) & (left_q == 4'h1) & wr_mode_q;
	assign crc_tx = rd_ld_q;
	assign crc_w  = rd_ld_q ? rd_data : cmd;

	logic safe_pend_q;
	always_ff @(posedge clk) begin
		if (!rst_b || cs_high) safe_pend_q <= 1'b0;
		else safe_pend_q <= safe_ld | safe_ld_wr;
	end

	// tx_word crosses as stable data, qualified by a toggle; the master's
	// turnaround wait covers the word toggle sync into clk and the register read
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tx_word_q <= '0;
			tx_en_q   <= 1'b0;
			ld_tog_q  <= 1'b0;
		end else if (cs_high) begin
			tx_en_q  <= 1'b0;
			ld_tog_q <= 1'b0; // link side clears its copy on select high
		end else if (rd_ld_q) begin
			tx_word_q <= rd_data;
			tx_en_q   <= 1'b1;
			ld_tog_q  <= ~ld_tog_q;
		end else if (safe_pend_q) begin
			tx_word_q <= safe_w;
			tx_en_q   <= 1'b1;
			ld_tog_q  <= ~ld_tog_q;
		end
	end

	chk_crc_seed: assert property (@(posedge clk) disable iff (!rst_b)
		cs_high |=> crc_q == CRC_SEED) else $error("crc not reseeded");
	chk_vr_sticky: assert property (@(posedge clk) disable iff (!rst_b)
		vr_set |=> vr_err_q) else $error("supply error not set");
	chk_filter_min: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(vr_err_q) |-> $past(sf_sync_q[1])) else $error("error set early");
	chk_abort_state: assert property (@(posedge clk) disable iff (!rst_b)
		cs_high |=> st_q == SSSP_CMD) else $error("no abort");
	chk_oe_select: assert property (@(posedge clk) disable iff (!rst_b)
		cs_high |=> ##1 !tx_en_q) else $error("driver left on");
	chk_status_clear: assert property (@(posedge clk) disable iff (!rst_b)
		status_rd && !vr_set |=> !vr_err_q) else $error("status not cleared");
	chk_addr_wrap: assert property (@(posedge clk) disable iff (!rst_b)
		adv && st_q == SSSP_DATA && !cs_high |=> addr_q == $past(addr_q) + 6'h01)
		else $error("bad address step");
	chk_cnt_zero: assert property (@(posedge clk) disable iff (!rst_b)
		adv && st_q == SSSP_DATA && left_q == 4'h0 && !cs_high |=> st_q == SSSP_DONE)
		else $error("safety after count zero");
endmodule // sssp_port

//--- sssp_port_tb.sv
`timescale 1ns/10ps
module sssp_port_tb;
	import sssp_pkg::*;
	localparam int FILT = 8;
	logic              clk, rst_b, sclk, chip_select_n, data_line, data_out, data_oe;
	logic              m_data, m_oe, float_q, supply_fault, sens_we, write_strobe;
	logic              regulator_voltage_error, oe0;
	logic [ADDR_W-1:0] sens_addr, write_addr, wa;
	logic [WORD_W-1:0] sens_data, write_word, ww, rx0;
	logic [WORD_W-1:0] mem [NREG];
	logic [WORD_W-1:0] shot [NREG];
	logic [31:0]       lfsr_q;
	int                n_errors, checks, n_wr, k0;

	// an undriven line shows a changing pattern, never the last value
	assign data_line = data_oe ? data_out : (m_oe ? m_data : float_q);
	always #4 clk = ~clk;
	always @(posedge clk) float_q <= ~float_q;
	always @(posedge clk) if (write_strobe === 1'b1) begin
		n_wr++;
		ww = write_word;
		wa = write_addr;
	end

	sssp_port #(.FILTER_CYC(FILT)) dut_u (.clk(clk), .rst_b(rst_b), .sclk(sclk),
		.chip_select_n(chip_select_n), .data_in(data_line), .data_out(data_out),
		.data_oe(data_oe), .supply_fault(supply_fault), .sens_addr(sens_addr),
		.sens_data(sens_data), .sens_we(sens_we), .write_word(write_word),
		.regulator_voltage_error(regulator_voltage_error), .write_addr(write_addr),
		.write_strobe(write_strobe));
	sssp_master m_u (.sclk(sclk), .chip_select_n(chip_select_n), .m_data(m_data),
		.m_oe(m_oe), .data_line(data_line), .dev_oe(data_oe));

	function automatic logic [31:0] rnd();
		lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
		return lfsr_q;
	endfunction

	// bitwise msb-first division, same result as high byte then low byte
	function automatic logic [7:0] crc_w(input logic [7:0] c, input logic [15:0] w);
		logic [7:0] r;
		r = c;
		for (int i = 15; i >= 0; i--) r = (r[7] ^ w[i]) ? ((r << 1) ^ 8'h1D) : (r << 1);
		return r;
	endfunction

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic sens_wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge clk);
		#1 {sens_addr, sens_data, sens_we} = {a, d, 1'b1};
		@(posedge clk);
		#1 sens_we = 1'b0;
		mem[a] = d;
	endtask

	// em: 0 no error expected, 1 error expected, 2 error bit not compared
	task automatic xfer(input logic rw, input logic snap, input logic [5:0] a,
		input logic [3:0] nd, input int em, input logic [15:0] d);
		logic [15:0] cmd, rx, w, m;
		logic [7:0]  crc;
		logic        oe;
		int          k;
		k = n_wr;
		cmd = {rw, 4'h0, snap, a, nd};
		m_u.select();
		m_u.word(cmd, 1'b1, 16, rx, oe);
		chk(oe, 1'b0);
		crc = crc_w(8'hFF, cmd);
		if (!rw) begin
			m_u.word(d, 1'b1, 16, rx, oe);
			crc = crc_w(crc, d);
		end
		m_u.turn();
		for (int j = 0; rw && j < ((nd == 0) ? 1 : nd); j++) begin
			w = snap ? shot[a + 6'(j)] : mem[a + 6'(j)];
			m_u.word(16'h0, 1'b0, 16, rx, oe);
			chk(rx, w);
			crc = crc_w(crc, w);
		end
		m_u.word(16'h0, 1'b0, 16, rx, oe);
		m = (em == 2) ? 16'h4000 : 16'h0;
		if (nd == 0) chk(oe, 1'b0);
		else chk(rx | m, {1'b1, 1'(em != 1), 6'h3F, ~crc} | m);
		m_u.release_sel();
		if (!rw) begin
			chk(16'(n_wr - k), 16'h1);
			chk(ww, d);
			chk(16'(wa), 16'(a));
		end
	endtask

	initial begin
		#600000;
		n_errors++;
		conclude();
	end

	initial begin
		{clk, rst_b, float_q, supply_fault, sens_we} = 5'h0;
		{sens_addr, sens_data} = '0;
		lfsr_q = 32'h45A9;
		n_errors = 0;
		checks = 0;
		n_wr = 0;
		repeat (10) @(posedge clk);
		#1 rst_b = 1'b1;
		repeat (4) @(posedge clk);
		for (int i = 0; i < NREG; i++) sens_wr(6'(i), 16'(rnd()));
		m_u.select();
		m_u.release_sel();
		shot = mem;
		#1000;
		for (int i = 0; i < NREG; i++) sens_wr(6'(i), 16'(rnd()));
		xfer(1'b1, 1'b1, 6'h3E, 4'h3, 0, 16'h0);
		xfer(1'b1, 1'b0, 6'h3E, 4'h3, 0, 16'h0);
		xfer(1'b1, 1'b0, 6'h3F, 4'h0, 0, 16'h0);
		for (int i = 0; i < 6; i++) xfer(1'b1, 1'(rnd()), 6'(rnd()), 4'(rnd()), 0, 16'h0);
		xfer(1'b0, 1'b0, 6'h15, 4'h1, 0, 16'(rnd()));
		// abort inside the first data word: nothing may be written
		k0 = n_wr;
		m_u.select();
		m_u.word({1'b0, 4'h0, 1'b0, 6'h09, 4'h1}, 1'b1, 16, rx0, oe0);
		m_u.word(16'hA5A5, 1'b1, 10, rx0, oe0);
		m_u.release_sel();
		chk(16'(n_wr - k0), 16'h0);
		xfer(1'b1, 1'b0, 6'h09, 4'h1, 0, 16'h0);
		@(posedge clk);
		#1 supply_fault = 1'b1;
		repeat (FILT - 3) @(posedge clk);
		#1 supply_fault = 1'b0;
		repeat (6) @(posedge clk);
		#1 chk(regulator_voltage_error, 1'b0);
		supply_fault = 1'b1;
		repeat (FILT + 6) @(posedge clk);
		#1 chk(regulator_voltage_error, 1'b1);
		supply_fault = 1'b0;
		xfer(1'b1, 1'b0, 6'h05, 4'h1, 1, 16'h0);
		xfer(1'b1, 1'b0, 6'h00, 4'h1, 2, 16'h0);
		chk(regulator_voltage_error, 1'b0);
		xfer(1'b1, 1'b0, 6'h07, 4'h1, 0, 16'h0);
		conclude();
	end
endmodule // sssp_port_tb

//--- sssp_regfile.sv
`timescale 1ns/10ps
// live registers with a snapshot copy and registered read port
module sssp_regfile #(
	parameter int AW = 6,
	parameter int DW = 16
) (
	input  wire logic          clk,
	input  wire logic          rst_b,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data,
	input  wire logic          wr_en,
	input  wire logic          snap,
	input  wire logic [AW-1:0] rd_addr,
	input  wire logic          rd_snap,
	output logic      [DW-1:0] rd_data
);
	localparam int N = 1 << AW;
	logic [DW-1:0] live_q [N];
	logic [DW-1:0] buf_q  [N];

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			for (int i = 0; i < N; i++) live_q[i] <= '0;
		end else if (wr_en) begin
			live_q[wr_addr] <= wr_data;
		end
	end

	// all buffered words captured in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			for (int i = 0; i < N; i++) buf_q[i] <= '0;
		end else if (snap) begin
			for (int i = 0; i < N; i++) buf_q[i] <= live_q[i];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) rd_data <= '0;
		else rd_data <= rd_snap ? buf_q[rd_addr] : live_q[rd_addr];
	end
endmodule // sssp_regfile
